/* File: hw/pic_top.v */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_top #(
   parameter W = 16
) (
   // clock and reset
   input  wire         mclk,
   input  wire         sys_rst,
   // apb slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output wire         pready,
   output reg  [31:0]  prdata,
   output wire         pslverr,
   // fault pins, asynchronous
   input  wire [3:0]   fault_in,
   // trigger pulses, six per generator
   output wire [23:0]  trig_out,
   // interrupt
   output wire         irq
);
   wire        wr = psel & penable & pwrite;
   wire        rd = psel & ~penable & ~pwrite;
   reg  [7:0]  mod_en;
   reg  [3:0]  fault_raw;
   reg  [3:0]  f_s1;
   reg  [3:0]  f_s2;
   reg  [3:0]  f_s3;
   reg  [13:0] gen_en  [0:3];
   reg  [W-1:0] cmpa   [0:3];
   reg  [W-1:0] cmpb   [0:3];
   wire [W-1:0] per_rd [0:3];
   wire [5:0]  g_raw   [0:3];
   wire [5:0]  g_mask  [0:3];
   wire [3:0]  g_irq;
   wire [7:0]  mod_raw = {fault_raw, g_irq};
   wire [7:0]  mod_mis = mod_raw & mod_en;
   wire [1:0]  gi = paddr[7:6] - 2'h1;
   wire        in_gen = (paddr[11:6] >= 6'h01) && (paddr[11:6] <= 6'h04);
   wire [5:0]  goff = paddr[5:0];
   reg         slverr_q;
   integer     k;

   // single-cycle access; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & slverr_q;
   // level held while any unmasked bit stands
   assign irq     = |mod_mis;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gens
         pic_gen #(.W(W)) u_gen (
            .mclk        (mclk),
            .sys_rst     (sys_rst),
            .period_wr   (pwdata[W-1:0]),
            .period_we   (wr && in_gen && gi == g && goff == `PIC_GEN_PERIOD_OFF),
            .cmp_a       (cmpa[g]),
            .cmp_b       (cmpb[g]),
            .enable      (gen_en[g]),
            .clear       ((wr && in_gen && gi == g && goff == `PIC_GEN_RIS_OFF)
                          ? pwdata[5:0] : 6'h00),
            .period_prog (per_rd[g]),
            .raw         (g_raw[g]),
            .masked      (g_mask[g]),
            .trig        (trig_out[6*g+5:6*g]),
            .gen_irq     (g_irq[g])
         );
      end
   endgenerate

   // fault pins resynchronised, then edge-caught into sticky status
   always @(posedge mclk) begin
      if (sys_rst) begin
         f_s1      <= 4'h0;
         f_s2      <= 4'h0;
         f_s3      <= 4'h0;
         fault_raw <= 4'h0;
      end else begin
         f_s1 <= fault_in;
         f_s2 <= f_s1;
         f_s3 <= f_s2;
         // set wins over clear so a fault in the clear cycle stays
         if (wr && paddr == `PIC_MOD_CLR_OFF)
            fault_raw <= (fault_raw & ~pwdata[`PIC_FAULT_LSB+3:`PIC_FAULT_LSB])
                         | (f_s2 & ~f_s3);
         else
            fault_raw <= fault_raw | (f_s2 & ~f_s3);
      end
   end

   // register writes
   always @(posedge mclk) begin
      if (sys_rst) begin
         mod_en <= 8'h00;
         for (k = 0; k < 4; k = k + 1) begin
            gen_en[k] <= 14'h0000;
            cmpa[k]   <= `PIC_CMP_RST;
            cmpb[k]   <= `PIC_CMP_RST;
         end
      end else if (wr) begin
         if (paddr == `PIC_MOD_EN_OFF)
            mod_en <= {pwdata[`PIC_FAULT_LSB+3:`PIC_FAULT_LSB], pwdata[3:0]};
         if (in_gen) begin
            // enable bits set and cleared by write
            if (goff == `PIC_GEN_EN_OFF)
               gen_en[gi] <= {pwdata[13:8], 2'b00, pwdata[5:0]};
            if (goff == `PIC_GEN_CMPA_OFF)
               cmpa[gi] <= pwdata[W-1:0];
            if (goff == `PIC_GEN_CMPB_OFF)
               cmpb[gi] <= pwdata[W-1:0];
         end
      end
   end

   // read data captured in setup phase
   always @(posedge mclk) begin
      if (sys_rst) begin
         prdata   <= 32'h00000000;
         slverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata   <= 32'h00000000;
         slverr_q <= 1'b0;
         if (in_gen) begin
            case (goff)
               `PIC_GEN_PERIOD_OFF: if (rd) prdata[W-1:0] <= per_rd[gi];
               `PIC_GEN_EN_OFF:     if (rd) prdata <= {18'h0, gen_en[gi][13:8],
                                                     2'h0, gen_en[gi][5:0]};
               `PIC_GEN_RIS_OFF:    if (rd) prdata[5:0] <= g_raw[gi];
               `PIC_GEN_MIS_OFF:    if (rd) prdata[5:0] <= g_mask[gi];
               `PIC_GEN_CMPA_OFF:   if (rd) prdata[W-1:0] <= cmpa[gi];
               `PIC_GEN_CMPB_OFF:   if (rd) prdata[W-1:0] <= cmpb[gi];
               default:             slverr_q <= 1'b1;
            endcase
         end else begin
            case (paddr)
               `PIC_MOD_EN_OFF:  if (rd) prdata <= {12'h0, mod_en[7:4], 12'h0, mod_en[3:0]};
               `PIC_MOD_RIS_OFF: if (rd) prdata <= {12'h0, mod_raw[7:4], 12'h0, mod_raw[3:0]};
               `PIC_MOD_MIS_OFF: if (rd) prdata <= {12'h0, mod_mis[7:4], 12'h0, mod_mis[3:0]};
               `PIC_MOD_CLR_OFF: prdata <= 32'h00000000;
               default:          slverr_q <= 1'b1;
            endcase
         end
      end
   end
endmodule

/* File: hw/pic_map.vh */
`ifndef PIC_MAP_VH
`define PIC_MAP_VH
// module-level registers
`define PIC_MOD_EN_OFF     12'h000
`define PIC_MOD_RIS_OFF    12'h004
`define PIC_MOD_MIS_OFF    12'h008
`define PIC_MOD_CLR_OFF    12'h00C
// generator block n starts at base + n * stride
`define PIC_GEN_BASE       12'h040
`define PIC_GEN_STRIDE     12'h040
`define PIC_GEN_PERIOD_OFF 12'h000
`define PIC_GEN_EN_OFF     12'h004
`define PIC_GEN_RIS_OFF    12'h008
`define PIC_GEN_MIS_OFF    12'h00C
`define PIC_GEN_CMPA_OFF   12'h010
`define PIC_GEN_CMPB_OFF   12'h014
// event bit positions, interrupt enables in 5:0, trigger enables in 13:8
`define PIC_EV_ZERO        0
`define PIC_EV_LOAD        1
`define PIC_EV_AU          2
`define PIC_EV_AD          3
`define PIC_EV_BU          4
`define PIC_EV_BD          5
`define PIC_TRIG_LSB       8
// module status: generators 3:0, faults 19:16
`define PIC_FAULT_LSB      16
// reset values
`define PIC_PERIOD_RST     16'h00FF
`define PIC_CMP_RST        16'h0000
`endif

/* File: hw/pic_gen.v */
`timescale 1ns/1ps
`include "pic_map.vh"
// one up/down counter generator with buffered period and event flags
module pic_gen #(
   parameter W = 16
) (
   // clock and reset
   input  wire         mclk,
   input  wire         sys_rst,
   // configuration
   input  wire [W-1:0] period_wr,
   input  wire         period_we,
   input  wire [W-1:0] cmp_a,
   input  wire [W-1:0] cmp_b,
   input  wire [13:0]  enable,
   input  wire [5:0]   clear,
   // state
   output reg  [W-1:0] period_prog,
   output reg  [5:0]   raw,
   output wire [5:0]   masked,
   output reg  [5:0]   trig,
   output wire         gen_irq
);
   reg  [W-1:0] period_act;
   reg  [W-1:0] count;
   reg          pending;
   wire [W-1:0] one     = {{(W-1){1'b0}}, 1'b1};
   wire [W-1:0] half    = period_act >> 1;
   // distance back to zero while on the falling slope
   wire [W-1:0] back    = period_act - count;
   wire         rising  = count < half;
   wire         falling = count > half;
   wire         at_zero = (count == {W{1'b0}});
   wire         at_load = (count == half);
   wire         at_wrap = (count >= period_act - one);
   wire [5:0]   ev;

   // one linear tick counter folded into a triangle: up to half, back to zero
   // trade-off: keeps zero pulses exactly period ticks apart, odd periods too
   assign ev[`PIC_EV_ZERO] = at_zero;
   assign ev[`PIC_EV_LOAD] = at_load;
   assign ev[`PIC_EV_AU]   = (count == cmp_a) && rising;
   assign ev[`PIC_EV_AD]   = (back == cmp_a) && falling;
   assign ev[`PIC_EV_BU]   = (count == cmp_b) && rising;
   assign ev[`PIC_EV_BD]   = (back == cmp_b) && falling;

   assign masked  = raw & enable[5:0];
   assign gen_irq = |masked;

   // counter and period buffer; new period applied only at zero
   always @(posedge mclk) begin
      if (sys_rst) begin
         count       <= {W{1'b0}};
         period_act  <= `PIC_PERIOD_RST;
         period_prog <= `PIC_PERIOD_RST;
         pending     <= 1'b0;
      end else begin
         if (period_we) begin
            period_prog <= period_wr;
            pending     <= 1'b1;
         end
         if (at_wrap) begin
            count <= {W{1'b0}};
            if (pending && !period_we) begin
               period_act <= period_prog;
               pending    <= 1'b0;
            end
         end else begin
            count <= count + one;
         end
      end
   end

   // sticky flags, set wins over clear; triggers are one-cycle pulses
   always @(posedge mclk) begin
      if (sys_rst) begin
         raw  <= 6'h00;
         trig <= 6'h00;
      end else begin
         raw  <= (raw & ~clear) | ev;
         trig <= ev & enable[13:8];
      end
   end
endmodule

/* File: dv/pic_chk.sv */
`timescale 1ns/1ps
// watches bus answers, triggers and the interrupt pin
module pic_chk #(
   parameter W = 16
) (
   // clock and reset
   input wire        mclk,
   input wire        sys_rst,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // outputs
   input wire [23:0] trig_out,
   input wire        irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // access phase under way
   wire acc = psel && penable;
   a_zero_wait: assert property (acc |-> pready) else $error("wait state");
   a_bad_addr: assert property (acc && paddr == 12'hFFC |-> pslverr) else $error("no err");
   a_good_addr: assert property (acc && paddr == 12'h000 |-> !pslverr) else $error("err");
   a_err_rd_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("err read data");
   a_rd_hold: assert property (!psel |=> $stable(prdata)) else $error("read data moved");
   // only software may drop the request, never the hardware itself
   a_irq_held: assert property ($fell(irq) |-> $past(acc && pwrite)) else $error("irq fell");
   a_trig_pulse: assert property ((trig_out & $past(trig_out)) == 24'h0)
      else $error("trig too long");
   a_rst_quiet: assert property ($fell(sys_rst) |-> !irq && trig_out == 24'h0)
      else $error("not quiet");
   c_irq: cover property ($rose(irq));
   c_err: cover property (acc && pslverr);
   c_trig: cover property (|trig_out);
endmodule
bind pic_top pic_chk #(.W(W)) u_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .trig_out(trig_out), .irq(irq));

/* File: dv/pic_top_tb_top.sv */
`timescale 1ns/1ps
`include "pic_map.vh"
// register level bench, software and the fault pins are the only partners
module pic_top_tb_top;
   logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  fault_in;
   logic [23:0] trig_out, seen;
   int          n_fail, n_checks, cyc, last, gap, g;
   pic_top uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .fault_in(fault_in), .trig_out(trig_out), .irq(irq));
   always #12.5 mclk = ~mclk;
   // cycle count, trigger history and zero pulse spacing
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      seen <= sys_rst ? 24'h0 : seen | trig_out;
      if (trig_out[0] === 1'b1) begin
         last <= cyc;
         gap <= cyc - last;
      end
      if (cyc == 4000) begin
         n_fail++;
         stop_test;
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", s, e, v);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   function automatic logic [11:0] ga(input int n, input logic [11:0] o);
      return `PIC_GEN_BASE + n[11:0] * `PIC_GEN_STRIDE + o;
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      {mclk, psel, penable, pwrite, paddr, pwdata, fault_in, cyc} = '0;
      sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      // reset values, then only the last of two period writes stays
      for (g = 0; g < 4; g++) begin
         rd(ga(g, 0), 32'h00FF);
         rd(ga(g, 4), 32'h0);
         xfer(1'b1, ga(g, 0), 32'h20 + g);
         xfer(1'b1, ga(g, 0), 32'h10 + g);
         rd(ga(g, 0), 32'h10 + g);
      end
      xfer(1'b1, ga(0, `PIC_GEN_CMPA_OFF), 32'h3);
      xfer(1'b1, ga(0, `PIC_GEN_CMPB_OFF), 32'h6);
      repeat (1200) @(posedge mclk);
      rd(ga(0, 8), 32'h3F);
      rd(ga(0, 12), 32'h0);
      rd(`PIC_MOD_RIS_OFF, 32'h0);
      chk("trig", 24'h0, seen);
      $display("events test done");
      // zero trigger only, spacing equals the period
      xfer(1'b1, ga(0, 4), 32'h101);
      repeat (100) @(posedge mclk);
      chk("trig", 24'h1, seen);
      chk("gap", 32'h10, gap);
      xfer(1'b1, `PIC_MOD_EN_OFF, 32'h1);
      chk("irq", 1, irq);
      rd(ga(0, 12), 32'h1);
      rd(`PIC_MOD_MIS_OFF, 32'h1);
      xfer(1'b1, `PIC_MOD_EN_OFF, 32'h0);
      chk("irq", 0, irq);
      xfer(1'b1, `PIC_MOD_EN_OFF, 32'h1);
      xfer(1'b1, ga(0, 4), 32'h100);
      chk("irq", 0, irq);
      xfer(1'b1, ga(0, 4), 32'h101);
      xfer(1'b1, ga(0, 8), 32'h0);
      chk("irq", 1, irq);
      // clear early, right after a zero pulse
      for (int i = 0; i < 100 && trig_out[0] !== 1'b1; i++) @(posedge mclk);
      xfer(1'b1, ga(0, 8), 32'h3F);
      chk("irq", 0, irq);
      rd(ga(0, 12), 32'h0);
      $display("generator irq test done");
      // fault status, mask and clear
      xfer(1'b1, ga(0, 4), 32'h0);
      fault_in <= 4'h4;
      repeat (4) @(posedge mclk);
      fault_in <= 4'h0;
      repeat (4) @(posedge mclk);
      rd(`PIC_MOD_RIS_OFF, 32'h0004_0000);
      rd(`PIC_MOD_MIS_OFF, 32'h0);
      xfer(1'b1, `PIC_MOD_EN_OFF, 32'h0004_0000);
      chk("irq", 1, irq);
      xfer(1'b1, `PIC_MOD_CLR_OFF, 32'h0004_0000);
      rd(`PIC_MOD_RIS_OFF, 32'h0);
      chk("irq", 0, irq);
      rd(12'hFFC, 32'h0);
      chk("err", 1, err);
      $display("fault test done");
      stop_test;
   end
endmodule
